// File: acp_config_port.sv
`timescale 1ns/100ps
`default_nettype none
// What this block does
// - Remap lanes only while remap enable set
// - Output lane k takes its selected lane
// - Several outputs may share one lane
// - Nonzero pattern select replaces every sample outside low latency
// - Twenty-bit pattern, type from select field
// - Pattern steps decimated under decimation, unless full-rate selected
// - No test pattern in low latency
// - Code 0x02 gives ramp, custom step
// - Step counted in 20-bit LSBs
// - Low latency bypasses, nine-cycle sample delay
// - Low latency needs fast bit and DDR
// - Power down by register or pin; 3ms wake
// - Function codes route pins to power down
// - Power down acts only with sampling clock
// - After reset pin 0 is sync reference
// - Works in defaults without any programming
// - Write data captured on rising serial edges
// - Read data driven on falling serial edges
// - Read direction blocks register writes
module acp_config_port #(
	parameter int NUM_LANES = 16,
	parameter int LANE_W = 16,
	parameter int WAKE_CYCLES = acp_pkg::WAKE_CYCLES
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	input wire logic sclk,
	input wire logic serial_select_n,
	input wire logic sdio_i,
	output logic sdio_o,
	output logic sdio_oe,
	input wire logic aux_pin_0,
	input wire logic aux_pin_1,
	input wire logic sample_clk_alive,
	input wire logic ddr_mode,
	input wire logic decim_en,
	input wire logic samp_tick,
	input wire logic dec_tick,
	input wire logic [LANE_W-1:0] raw_sample,
	input wire logic [NUM_LANES*LANE_W-1:0] internal_lane,
	output logic [NUM_LANES*LANE_W-1:0] dout_lane,
	output logic [LANE_W-1:0] fast_sample,
	output logic pattern_active,
	output logic fast_path_active,
	output logic power_down,
	output logic wake_busy,
	output logic sync_reference
);

	localparam int NSEL = 8;
	localparam int WAKE_W = $clog2(WAKE_CYCLES + 1);

	// ----------------------------------------------------------------
	// Serial side, clocked by the controller's serial clock.
	// ----------------------------------------------------------------
	logic [4:0] bit_cnt_r;
	logic [22:0] shift_r;
	logic rd_dir_r;
	logic [11:0] rd_addr_r;
	logic [11:0] wr_addr_r;
	logic [7:0] wr_data_r;
	logic wr_tgl_r;
	logic [6:0] rd_sh_r;
	logic sdio_o_r;
	logic sdio_oe_r;
	logic [7:0] rd_data_w;

	// Bit counter; a high select clears it at once, since the clock may stop.
	always_ff @(posedge sclk or posedge serial_select_n) begin
		if (serial_select_n) begin
			bit_cnt_r <= 5'h00;
		end else if (bit_cnt_r != acp_pkg::CNT_DONE) begin
			bit_cnt_r <= bit_cnt_r + 5'h01;
		end
	end

	// Every bit, address and data, enters on a rising edge, MSB first.
	always_ff @(posedge sclk) begin
		shift_r <= {shift_r[21:0], sdio_i};
	end

	// Direction and address are latched as the sixteenth bit arrives.
	always_ff @(posedge sclk) begin
		if (!serial_select_n && bit_cnt_r == acp_pkg::CNT_ADDR_LAST) begin
			rd_dir_r <= shift_r[14];
			rd_addr_r <= {shift_r[10:0], sdio_i};
		end
	end

	// A finished write frame is handed over by a toggle. The address and
	// data words stay still until the next frame ends, far longer than the
	// crossing takes. The async clear exists because this clock may not run.
	always_ff @(posedge sclk or posedge rst) begin
		if (rst) begin
			wr_tgl_r <= 1'b0;
			wr_addr_r <= 12'h000;
			wr_data_r <= 8'h00;
		end else if (!serial_select_n && bit_cnt_r == acp_pkg::CNT_DATA_LAST && !rd_dir_r) begin
			wr_addr_r <= rd_addr_r;
			wr_data_r <= {shift_r[6:0], sdio_i};
			wr_tgl_r <= ~wr_tgl_r;
		end
	end

	// Read data leaves on falling edges. Register contents are quasi-static
	// here: writes are blocked during a read, so the word is sampled directly.
	always_ff @(negedge sclk or posedge serial_select_n) begin
		if (serial_select_n) begin
			sdio_o_r <= 1'b0;
			sdio_oe_r <= 1'b0;
			rd_sh_r <= 7'h00;
		end else if (rd_dir_r && bit_cnt_r == acp_pkg::CNT_READ_FIRST) begin
			sdio_o_r <= rd_data_w[7];
			rd_sh_r <= rd_data_w[6:0];
			sdio_oe_r <= 1'b1;
		end else if (rd_dir_r && bit_cnt_r > acp_pkg::CNT_READ_FIRST && bit_cnt_r != acp_pkg::CNT_DONE) begin
			sdio_o_r <= rd_sh_r[6];
			rd_sh_r <= {rd_sh_r[5:0], 1'b0};
		end else begin
			sdio_oe_r <= 1'b0;
		end
	end

	assign sdio_o = sdio_o_r;
	assign sdio_oe = sdio_oe_r;

	// ----------------------------------------------------------------
	// Crossings and pin synchronisers into the system clock.
	// ----------------------------------------------------------------
	logic [2:0] tgl_s_r;
	logic [2:0] aux0_s_r;
	logic [2:0] aux1_s_r;
	logic [2:0] alive_s_r;
	logic aux0_r;
	logic aux1_r;
	logic alive_r;
	logic wr_evt;

	// Three stages each; the first stage is read only by the second.
	always_ff @(posedge clk) begin
		if (rst) begin
			tgl_s_r <= 3'h0;
			aux0_s_r <= 3'h0;
			aux1_s_r <= 3'h0;
			alive_s_r <= 3'h0;
		end else if (ce) begin
			tgl_s_r <= {tgl_s_r[1:0], wr_tgl_r};
			aux0_s_r <= {aux0_s_r[1:0], aux_pin_0};
			aux1_s_r <= {aux1_s_r[1:0], aux_pin_1};
			alive_s_r <= {alive_s_r[1:0], sample_clk_alive};
		end
	end

	// Pin levels change only once the last two stages agree.
	always_ff @(posedge clk) begin
		if (rst) begin
			aux0_r <= 1'b0;
			aux1_r <= 1'b0;
			alive_r <= 1'b0;
		end else if (ce) begin
			if (aux0_s_r[1] == aux0_s_r[2]) aux0_r <= aux0_s_r[2];
			if (aux1_s_r[1] == aux1_s_r[2]) aux1_r <= aux1_s_r[2];
			if (alive_s_r[1] == alive_s_r[2]) alive_r <= alive_s_r[2];
		end
	end

	assign wr_evt = ce && (tgl_s_r[1] != tgl_s_r[2]);

	// ----------------------------------------------------------------
	// Register file.
	// ----------------------------------------------------------------
	logic [7:0] pwr_ctrl_r;
	logic [7:0] lane_ctrl_r;
	logic [7:0] lane_sel_r [NSEL];
	logic [7:0] aux_func_r;
	logic [7:0] pat_ctrl_r;
	logic [7:0] pat_low_r;
	logic [7:0] fast_ctrl_r;
	logic [11:0] sel_off_w;

	assign sel_off_w = wr_addr_r - acp_pkg::ADDR_LANE_SOURCE_SELECT_FIRST;

	// Plain registers; reset leaves a working default device.
	always_ff @(posedge clk) begin
		if (rst) begin
			pwr_ctrl_r <= acp_pkg::RST_ZERO;
			lane_ctrl_r <= acp_pkg::RST_ZERO;
			aux_func_r <= acp_pkg::RST_ZERO;
			pat_ctrl_r <= acp_pkg::RST_ZERO;
			pat_low_r <= acp_pkg::RST_ZERO;
			fast_ctrl_r <= acp_pkg::RST_ZERO;
		end else if (wr_evt) begin
			unique case (wr_addr_r)
				acp_pkg::ADDR_POWER_CONTROL: pwr_ctrl_r <= wr_data_r;
				acp_pkg::ADDR_OUTPUT_LANE_CONTROL: lane_ctrl_r <= wr_data_r;
				acp_pkg::ADDR_AUX_PIN_FUNCTION: aux_func_r <= wr_data_r;
				acp_pkg::ADDR_PATTERN_CONTROL: pat_ctrl_r <= wr_data_r;
				acp_pkg::ADDR_PATTERN_CUSTOM_LOW: pat_low_r <= wr_data_r;
				acp_pkg::ADDR_FAST_PATH_CONTROL: fast_ctrl_r <= wr_data_r;
				default: ;
			endcase
		end
	end

	// Source select pairs; each resets to the straight-through mapping.
	genvar gs;
	generate
		for (gs = 0; gs < NSEL; gs++) begin : g_sel
			always_ff @(posedge clk) begin
				if (rst) begin
					lane_sel_r[gs] <= {4'(2 * gs + 1), 4'(2 * gs)};
				end else if (wr_evt && wr_addr_r >= acp_pkg::ADDR_LANE_SOURCE_SELECT_FIRST
						&& wr_addr_r <= acp_pkg::ADDR_LANE_SOURCE_SELECT_LAST
						&& sel_off_w[2:0] == 3'(gs)) begin
					lane_sel_r[gs] <= wr_data_r;
				end
			end
		end
	endgenerate

	// Read-back mux; unmapped addresses read as zero.
	always_comb begin
		rd_data_w = 8'h00;
		if (rd_addr_r >= acp_pkg::ADDR_LANE_SOURCE_SELECT_FIRST
				&& rd_addr_r <= acp_pkg::ADDR_LANE_SOURCE_SELECT_LAST) begin
			rd_data_w = lane_sel_r[3'(rd_addr_r - acp_pkg::ADDR_LANE_SOURCE_SELECT_FIRST)];
		end else begin
			unique case (rd_addr_r)
				acp_pkg::ADDR_POWER_CONTROL: rd_data_w = pwr_ctrl_r;
				acp_pkg::ADDR_OUTPUT_LANE_CONTROL: rd_data_w = lane_ctrl_r;
				acp_pkg::ADDR_AUX_PIN_FUNCTION: rd_data_w = aux_func_r;
				acp_pkg::ADDR_PATTERN_CONTROL: rd_data_w = pat_ctrl_r;
				acp_pkg::ADDR_PATTERN_CUSTOM_LOW: rd_data_w = pat_low_r;
				acp_pkg::ADDR_FAST_PATH_CONTROL: rd_data_w = fast_ctrl_r;
				default: rd_data_w = 8'h00;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Mode decode.
	// ----------------------------------------------------------------
	logic fast_nxt;
	logic [acp_pkg::PATTERN_SEL_W-1:0] pat_sel_w;
	logic [acp_pkg::AUX_FUNC_W-1:0] func_w;
	logic pat_on_nxt;
	logic pat_adv_w;

	assign pat_sel_w = pat_ctrl_r[acp_pkg::PATTERN_SEL_W-1:0];
	assign func_w = aux_func_r[acp_pkg::AUX_FUNC_W-1:0];
	assign fast_nxt = fast_ctrl_r[acp_pkg::BIT_FAST_PATH_EN] && ddr_mode;
	assign pat_on_nxt = (pat_sel_w != acp_pkg::PATTERN_OFF) && !fast_nxt;
	// Full-rate steps outside decimation or when the rate bit is set.
	assign pat_adv_w = (decim_en && !pat_ctrl_r[acp_pkg::BIT_PATTERN_CLK]) ? dec_tick : samp_tick;

	// Registered mode flags.
	always_ff @(posedge clk) begin
		if (rst) begin
			fast_path_active <= 1'b0;
			pattern_active <= 1'b0;
		end else if (ce) begin
			fast_path_active <= fast_nxt;
			pattern_active <= pat_on_nxt;
		end
	end

	// ----------------------------------------------------------------
	// Test pattern generator, after the down-conversion path.
	// ----------------------------------------------------------------
	logic [acp_pkg::PATTERN_W-1:0] pat_r;

	// Ramp accumulates in 20-bit LSBs; other codes hold the custom byte.
	always_ff @(posedge clk) begin
		if (rst) begin
			pat_r <= 20'h00000;
		end else if (ce) begin
			if (!pat_on_nxt) begin
				pat_r <= 20'h00000;
			end else if (pat_sel_w == acp_pkg::PATTERN_RAMP) begin
				if (pat_adv_w) pat_r <= pat_r + {12'h000, pat_low_r};
			end else begin
				pat_r <= {12'h000, pat_low_r};
			end
		end
	end

	// ----------------------------------------------------------------
	// Output lane mux.
	// ----------------------------------------------------------------
	genvar gl;
	generate
		for (gl = 0; gl < NUM_LANES; gl++) begin : g_lane
			logic [acp_pkg::LANE_SEL_W-1:0] src_w;
			// Odd lanes use the upper nibble of their pair register.
			assign src_w = lane_ctrl_r[acp_pkg::BIT_REMAP_EN]
				? lane_sel_r[gl / 2][(gl % 2) * 4 +: 4]
				: 4'(gl);
			always_ff @(posedge clk) begin
				if (rst) begin
					dout_lane[gl*LANE_W +: LANE_W] <= '0;
				end else if (ce) begin
					if (pat_on_nxt) begin
						dout_lane[gl*LANE_W +: LANE_W] <= pat_r[acp_pkg::PATTERN_W-1 -: LANE_W];
					end else begin
						// Any number of outputs may name the same source.
						dout_lane[gl*LANE_W +: LANE_W] <= internal_lane[src_w*LANE_W +: LANE_W];
					end
				end
			end
		end
	endgenerate

	// ----------------------------------------------------------------
	// Low latency sample path.
	// ----------------------------------------------------------------
	logic [LANE_W-1:0] fast_dly_r [acp_pkg::FAST_PATH_LATENCY];

	// A fixed nine-stage delay; counted in sample ticks, not system clocks.
	always_ff @(posedge clk) begin
		if (rst) begin
			for (int i = 0; i < acp_pkg::FAST_PATH_LATENCY; i++) fast_dly_r[i] <= '0;
		end else if (ce && samp_tick) begin
			fast_dly_r[0] <= fast_nxt ? raw_sample : '0;
			for (int i = 1; i < acp_pkg::FAST_PATH_LATENCY; i++) fast_dly_r[i] <= fast_dly_r[i-1];
		end
	end
	assign fast_sample = fast_dly_r[acp_pkg::FAST_PATH_LATENCY-1];

	// ----------------------------------------------------------------
	// Power down and auxiliary pins.
	// ----------------------------------------------------------------
	logic pdn_req_w;
	logic [WAKE_W-1:0] wake_cnt_r;

	assign pdn_req_w = pwr_ctrl_r[acp_pkg::BIT_GLOBAL_PDN]
		|| (func_w == acp_pkg::AUX_FUNC_PDN_PIN1 && aux1_r)
		|| ((func_w == acp_pkg::AUX_FUNC_PDN_PIN0_A || func_w == acp_pkg::AUX_FUNC_PDN_PIN0_B) && aux0_r);

	// Entry and exit follow the request only while sampling runs.
	always_ff @(posedge clk) begin
		if (rst) begin
			power_down <= 1'b0;
		end else if (ce && alive_r) begin
			power_down <= pdn_req_w;
		end
	end

	// Wake-up interval counted from leaving power down.
	always_ff @(posedge clk) begin
		if (rst) begin
			wake_cnt_r <= '0;
			wake_busy <= 1'b0;
		end else if (ce) begin
			if (power_down && alive_r && !pdn_req_w) begin
				wake_cnt_r <= WAKE_W'(WAKE_CYCLES);
				wake_busy <= 1'b1;
			end else if (wake_cnt_r != '0) begin
				wake_cnt_r <= wake_cnt_r - 1'b1;
				wake_busy <= (wake_cnt_r != WAKE_W'(1));
			end
		end
	end

	// Pin 0 acts as the sync reference under the default function code.
	always_ff @(posedge clk) begin
		if (rst) begin
			sync_reference <= 1'b0;
		end else if (ce) begin
			sync_reference <= (func_w == acp_pkg::AUX_FUNC_DEFAULT) && aux0_r;
		end
	end

	// ----------------------------------------------------------------
	// Checks.
	// ----------------------------------------------------------------
	sequence s_ramp_step;
		ce && pat_on_nxt && pat_sel_w == acp_pkg::PATTERN_RAMP && pat_adv_w;
	endsequence

	sequence s_pdn_leave;
		ce && alive_r && power_down && !pdn_req_w;
	endsequence

	write_lands_a: assert property (@(posedge clk) disable iff (rst)
		wr_evt && wr_addr_r == acp_pkg::ADDR_PATTERN_CUSTOM_LOW |=> pat_low_r == $past(wr_data_r))
		else $error("written byte did not reach its register");

	read_blocks_write_a: assert property (@(posedge sclk) disable iff (rst || serial_select_n)
		rd_dir_r && bit_cnt_r == acp_pkg::CNT_DATA_LAST |=> wr_tgl_r == $past(wr_tgl_r))
		else $error("read frame changed the write toggle");

	no_pattern_fast_a: assert property (@(posedge clk) disable iff (rst)
		fast_path_active |-> !pattern_active)
		else $error("pattern active in low latency mode");

	ramp_step_a: assert property (@(posedge clk) disable iff (rst)
		s_ramp_step |=> pat_r == $past(pat_r) + {12'h000, $past(pat_low_r)})
		else $error("ramp did not advance by the custom step");

	pdn_needs_clock_a: assert property (@(posedge clk) disable iff (rst)
		!alive_r |=> power_down == $past(power_down))
		else $error("power down changed without sampling clock");

	// The sampled reset keeps the release edge out, since lanes were zeroed there.
	lane_default_a: assert property (@(posedge clk) disable iff (rst)
		!rst && ce && !lane_ctrl_r[acp_pkg::BIT_REMAP_EN] && !pat_on_nxt
		|=> dout_lane[LANE_W +: LANE_W] == $past(internal_lane[LANE_W +: LANE_W]))
		else $error("lane one not on default mapping");

	wake_start_a: assert property (@(posedge clk) disable iff (rst)
		s_pdn_leave |=> !power_down ##0 wake_busy ##0 wake_cnt_r == WAKE_W'(WAKE_CYCLES))
		else $error("wake interval did not start on exit");

	pin_pdn_a: assert property (@(posedge clk) disable iff (rst)
		ce && alive_r && func_w == acp_pkg::AUX_FUNC_PDN_PIN1 && aux1_r |=> power_down)
		else $error("pin one did not power down");

	sync_default_a: assert property (@(posedge clk) disable iff (rst)
		ce && func_w == acp_pkg::AUX_FUNC_DEFAULT ##1 ce |-> sync_reference == $past(aux0_r))
		else $error("pin zero not routed to sync reference");

	pin_idle_a: assert property (@(negedge sclk) disable iff (rst || serial_select_n)
		sdio_oe_r |-> rd_dir_r)
		else $error("data pin driven outside a read");

endmodule
`default_nettype wire

// File: acp_pkg.sv
package acp_pkg;

	// ----------------------------------------------------------------
	// Register offsets on the serial port (12-bit address field).
	// ----------------------------------------------------------------
	localparam logic [11:0] ADDR_POWER_CONTROL = 12'h101;
	localparam logic [11:0] ADDR_OUTPUT_LANE_CONTROL = 12'h116;
	localparam logic [11:0] ADDR_LANE_SOURCE_SELECT_FIRST = 12'h117;
	localparam logic [11:0] ADDR_LANE_SOURCE_SELECT_LAST = 12'h11E;
	localparam logic [11:0] ADDR_AUX_PIN_FUNCTION = 12'h146;
	localparam logic [11:0] ADDR_PATTERN_CONTROL = 12'h14A;
	localparam logic [11:0] ADDR_PATTERN_CUSTOM_LOW = 12'h14B;
	localparam logic [11:0] ADDR_FAST_PATH_CONTROL = 12'h165;

	// ----------------------------------------------------------------
	// Field positions and codes.
	// ----------------------------------------------------------------
	localparam int BIT_REMAP_EN = 7;
	localparam int BIT_GLOBAL_PDN = 4;
	localparam int BIT_PATTERN_CLK = 4;
	localparam int BIT_FAST_PATH_EN = 4;
	localparam int PATTERN_SEL_W = 3;
	localparam int AUX_FUNC_W = 5;
	localparam int LANE_SEL_W = 4;
	localparam logic [PATTERN_SEL_W-1:0] PATTERN_OFF = 3'h0;
	localparam logic [PATTERN_SEL_W-1:0] PATTERN_RAMP = 3'h2;
	localparam logic [AUX_FUNC_W-1:0] AUX_FUNC_DEFAULT = 5'h00;
	localparam logic [AUX_FUNC_W-1:0] AUX_FUNC_PDN_PIN1 = 5'h03;
	localparam logic [AUX_FUNC_W-1:0] AUX_FUNC_PDN_PIN0_A = 5'h0A;
	localparam logic [AUX_FUNC_W-1:0] AUX_FUNC_PDN_PIN0_B = 5'h0B;

	// ----------------------------------------------------------------
	// Serial frame layout: 16 address bits then 8 data bits.
	// ----------------------------------------------------------------
	localparam int FRAME_ADDR_BITS = 16;
	localparam int FRAME_BITS = 24;
	localparam logic [4:0] CNT_ADDR_LAST = 5'h0F;
	localparam logic [4:0] CNT_READ_FIRST = 5'h10;
	localparam logic [4:0] CNT_DATA_LAST = 5'h17;
	localparam logic [4:0] CNT_DONE = 5'h18;

	// ----------------------------------------------------------------
	// Reset values.
	// ----------------------------------------------------------------
	localparam logic [7:0] RST_ZERO = 8'h00;

	// ----------------------------------------------------------------
	// Timing.
	// ----------------------------------------------------------------
	localparam int CLK_MHZ = 100;
	localparam int WAKE_TIME_US = 3000;
	localparam int WAKE_CYCLES = WAKE_TIME_US * CLK_MHZ;
	localparam int FAST_PATH_LATENCY = 9;
	localparam int PATTERN_W = 20;

endpackage

// File: acp_ctrl_model.sv
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------------------------------
// Serial controller model: owns select, serial clock and data drive.
// ----------------------------------------------------------------
module acp_ctrl_model #(
	parameter int HALF = 24
) (
	output logic sclk,
	output logic serial_select_n,
	output logic sdio_m,
	input wire logic sdio_w
);
	// The clock rests low and select rests high between frames.
	initial begin
		sclk = 1'b0;
		serial_select_n = 1'b1;
		sdio_m = 1'b0;
	end

	// One frame; a short bit count aborts it early to probe refusal.
	task automatic xfer(input logic rd, input logic [11:0] addr, input logic [7:0] wd, input int nbits,
		output logic [7:0] q);
		logic [23:0] word;
		word = {rd, 3'h0, addr, wd};
		q = 8'h00;
		serial_select_n = 1'b0;
		#(HALF);
		for (int i = 23; i >= 24 - nbits; i--) begin
			// A released line shows the inverse of the last value, so stale data never passes.
			sdio_m = (rd && i < 8) ? ~sdio_m : word[i];
			#(HALF);
			if (rd && i < 8) q = {q[6:0], sdio_w};
			sclk = 1'b1;
			#(HALF);
			sclk = 1'b0;
		end
		#(HALF);
		serial_select_n = 1'b1;
		sdio_m = ~sdio_m;
		#(4 * HALF);
	endtask
endmodule
`default_nettype wire

// File: test_adc_config_port_and_output_ctrl.sv
`timescale 1ns/100ps
`default_nettype none
module test_adc_config_port_and_output_ctrl;
	localparam int WAKE = 20;
	localparam int LIMIT = 30000;
	logic clk = 1'b0;
	logic rst, ce, sclk, serial_select_n, sdio_m, sdio_o, sdio_oe, aux_pin_0, aux_pin_1, sample_clk_alive;
	logic ddr_mode, decim_en, samp_tick, dec_tick, pattern_active, fast_path_active, power_down;
	logic wake_busy, sync_reference;
	logic [15:0] raw_sample, fast_sample;
	logic [255:0] internal_lane, dout_lane;
	logic [7:0] q;
	wire logic sdio_w;
	int n_errors = 0;
	int compares = 0;
	int cycles = 0;

	// ----------------------------------------------------------------
	// Clock, shared data pin and instances.
	// ----------------------------------------------------------------
	// The data pin shows the device only while it drives.
	assign sdio_w = sdio_oe ? sdio_o : sdio_m;
	always #5 clk = ~clk;

	acp_ctrl_model #(.HALF(24)) model (.sclk(sclk), .serial_select_n(serial_select_n), .sdio_m(sdio_m),
		.sdio_w(sdio_w));
	acp_config_port #(.NUM_LANES(16), .LANE_W(16), .WAKE_CYCLES(WAKE)) dut (.clk(clk), .rst(rst), .ce(ce),
		.sclk(sclk), .serial_select_n(serial_select_n), .sdio_i(sdio_w), .sdio_o(sdio_o), .sdio_oe(sdio_oe),
		.aux_pin_0(aux_pin_0), .aux_pin_1(aux_pin_1), .sample_clk_alive(sample_clk_alive),
		.ddr_mode(ddr_mode), .decim_en(decim_en), .samp_tick(samp_tick), .dec_tick(dec_tick),
		.raw_sample(raw_sample), .internal_lane(internal_lane), .dout_lane(dout_lane),
		.fast_sample(fast_sample), .pattern_active(pattern_active), .fast_path_active(fast_path_active),
		.power_down(power_down), .wake_busy(wake_busy), .sync_reference(sync_reference));

	// ----------------------------------------------------------------
	// Helpers.
	// ----------------------------------------------------------------
	// Four-state compare, so an unknown never passes.
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			n_errors++;
			$display("unexpected at %0t: got %h, expected %h", $time, got, exp);
		end
	endtask

	// Outputs are looked at on a falling edge, clear of the launching edge.
	task automatic settle(input int n);
		repeat (n) @(posedge clk);
		@(negedge clk);
	endtask

	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		logic [7:0] unused;
		model.xfer(1'b0, a, d, 24, unused);
		@(negedge clk);
	endtask

	task automatic rd_check(input logic [11:0] a, input logic [7:0] exp);
		logic [7:0] d;
		model.xfer(1'b1, a, 8'h00, 24, d);
		check(d, exp);
		check(sdio_oe, 1'b0);
		@(negedge clk);
	endtask

	// One-cycle strobe on the full-rate or the decimated tick.
	task automatic pulse(input logic dec);
		@(posedge clk);
		if (dec) dec_tick <= 1'b1;
		else samp_tick <= 1'b1;
		@(posedge clk);
		dec_tick <= 1'b0;
		samp_tick <= 1'b0;
	endtask

	task automatic give_verdict;
		$display("compares %0d, n_errors %0d", compares, n_errors);
		if (n_errors == 0 && compares > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	// ----------------------------------------------------------------
	// Scenarios.
	// ----------------------------------------------------------------
	task automatic t_defaults;
		rd_check(acp_pkg::ADDR_LANE_SOURCE_SELECT_FIRST, 8'h10);
		rd_check(acp_pkg::ADDR_LANE_SOURCE_SELECT_LAST, 8'hFE);
		rd_check(acp_pkg::ADDR_AUX_PIN_FUNCTION, 8'h00);
		check(dout_lane[16 +: 16], 16'h1001);
		@(posedge clk) aux_pin_0 <= 1'b1;
		settle(8);
		check(sync_reference, 1'b1);
		@(posedge clk) aux_pin_0 <= 1'b0;
		settle(8);
		check(sync_reference, 1'b0);
	endtask

	task automatic t_serial;
		wr(acp_pkg::ADDR_PATTERN_CUSTOM_LOW, 8'h5A);
		rd_check(acp_pkg::ADDR_PATTERN_CUSTOM_LOW, 8'h5A);
		model.xfer(1'b1, acp_pkg::ADDR_PATTERN_CUSTOM_LOW, 8'hC3, 24, q);
		rd_check(acp_pkg::ADDR_PATTERN_CUSTOM_LOW, 8'h5A);
		model.xfer(1'b0, acp_pkg::ADDR_PATTERN_CUSTOM_LOW, 8'h33, 20, q);
		rd_check(acp_pkg::ADDR_PATTERN_CUSTOM_LOW, 8'h5A);
		wr(12'h200, 8'hFF);
		rd_check(12'h200, 8'h00);
	endtask

	task automatic t_remap;
		wr(acp_pkg::ADDR_LANE_SOURCE_SELECT_FIRST, 8'h33);
		settle(1);
		check(dout_lane[0 +: 16], 16'h1000);
		wr(acp_pkg::ADDR_OUTPUT_LANE_CONTROL, 8'h80);
		settle(1);
		check(dout_lane[0 +: 16], 16'h1003);
		check(dout_lane[16 +: 16], 16'h1003);
		check(dout_lane[32 +: 16], 16'h1002);
		wr(acp_pkg::ADDR_OUTPUT_LANE_CONTROL, 8'h00);
		settle(1);
		check(dout_lane[16 +: 16], 16'h1001);
	endtask

	task automatic t_pattern;
		wr(acp_pkg::ADDR_PATTERN_CUSTOM_LOW, 8'hA0);
		wr(acp_pkg::ADDR_PATTERN_CONTROL, 8'h01);
		settle(1);
		check(pattern_active, 1'b1);
		check(dout_lane[0 +: 16], 16'h000A);
		wr(acp_pkg::ADDR_PATTERN_CONTROL, 8'h00);
		wr(acp_pkg::ADDR_PATTERN_CUSTOM_LOW, 8'h10);
		wr(acp_pkg::ADDR_PATTERN_CONTROL, 8'h02);
		settle(1);
		check(dout_lane[0 +: 16], 16'h0000);
		pulse(1'b0);
		settle(1);
		check(dout_lane[0 +: 16], 16'h0001);
		check(dout_lane[240 +: 16], 16'h0001);
		@(posedge clk) decim_en <= 1'b1;
		pulse(1'b0);
		settle(1);
		check(dout_lane[0 +: 16], 16'h0001);
		pulse(1'b1);
		settle(1);
		check(dout_lane[0 +: 16], 16'h0002);
		wr(acp_pkg::ADDR_PATTERN_CONTROL, 8'h12);
		pulse(1'b0);
		settle(1);
		check(dout_lane[0 +: 16], 16'h0003);
		@(posedge clk) decim_en <= 1'b0;
		@(posedge clk) ddr_mode <= 1'b1;
		wr(acp_pkg::ADDR_FAST_PATH_CONTROL, 8'h10);
		settle(1);
		check(fast_path_active, 1'b1);
		check(pattern_active, 1'b0);
		check(dout_lane[0 +: 16], 16'h1000);
		@(posedge clk) raw_sample <= 16'hABCD;
		repeat (8) pulse(1'b0);
		settle(0);
		check(fast_sample, 16'h0000);
		pulse(1'b0);
		settle(0);
		check(fast_sample, 16'hABCD);
		@(posedge clk) ddr_mode <= 1'b0;
		settle(2);
		check(fast_path_active, 1'b0);
		check(pattern_active, 1'b1);
		wr(acp_pkg::ADDR_PATTERN_CONTROL, 8'h00);
		wr(acp_pkg::ADDR_FAST_PATH_CONTROL, 8'h00);
		settle(1);
		check(pattern_active, 1'b0);
	endtask

	task automatic t_power;
		wr(acp_pkg::ADDR_POWER_CONTROL, 8'h10);
		settle(1);
		check(power_down, 1'b1);
		wr(acp_pkg::ADDR_POWER_CONTROL, 8'h00);
		check(wake_busy, 1'b1);
		settle(WAKE);
		check(wake_busy, 1'b0);
		@(posedge clk) sample_clk_alive <= 1'b0;
		settle(8);
		wr(acp_pkg::ADDR_POWER_CONTROL, 8'h10);
		settle(8);
		check(power_down, 1'b0);
		@(posedge clk) sample_clk_alive <= 1'b1;
		settle(8);
		check(power_down, 1'b1);
		wr(acp_pkg::ADDR_POWER_CONTROL, 8'h00);
		settle(WAKE + 8);
		wr(acp_pkg::ADDR_AUX_PIN_FUNCTION, 8'h03);
		@(posedge clk) aux_pin_1 <= 1'b1;
		settle(8);
		check(power_down, 1'b1);
		@(posedge clk) aux_pin_1 <= 1'b0;
		settle(8);
		check(power_down, 1'b0);
		wr(acp_pkg::ADDR_AUX_PIN_FUNCTION, 8'h0A);
		@(posedge clk) aux_pin_0 <= 1'b1;
		settle(8);
		check(power_down, 1'b1);
		check(sync_reference, 1'b0);
		wr(acp_pkg::ADDR_AUX_PIN_FUNCTION, 8'h0B);
		settle(8);
		check(power_down, 1'b1);
		@(posedge clk) aux_pin_0 <= 1'b0;
		settle(8);
		check(power_down, 1'b0);
		wr(acp_pkg::ADDR_AUX_PIN_FUNCTION, 8'h00);
		settle(WAKE + 8);
	endtask

	// A second reset in mid-run must bring the custom low byte and the first source select back.
	task automatic t_reset;
		wr(acp_pkg::ADDR_PATTERN_CUSTOM_LOW, 8'h77);
		@(posedge clk) rst <= 1'b1;
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		@(negedge clk);
		check(dout_lane[0 +: 16], 16'h0000);
		settle(1);
		check(dout_lane[0 +: 16], 16'h1000);
		rd_check(acp_pkg::ADDR_PATTERN_CUSTOM_LOW, 8'h00);
		rd_check(acp_pkg::ADDR_LANE_SOURCE_SELECT_FIRST, 8'h10);
	endtask

	// ----------------------------------------------------------------
	// Run and timeout.
	// ----------------------------------------------------------------
	initial begin
		rst = 1'b1;
		ce = 1'b1;
		aux_pin_0 = 1'b0;
		aux_pin_1 = 1'b0;
		sample_clk_alive = 1'b1;
		ddr_mode = 1'b0;
		decim_en = 1'b0;
		samp_tick = 1'b0;
		dec_tick = 1'b0;
		raw_sample = 16'h0000;
		for (int k = 0; k < 16; k++) internal_lane[k*16 +: 16] = 16'h1000 + 16'(k);
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		settle(2);
		t_defaults();
		t_serial();
		t_remap();
		t_pattern();
		t_power();
		t_reset();
		give_verdict();
	end

	// A hang counts as a mismatch and still reaches the verdict.
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == LIMIT) begin
			n_errors++;
			give_verdict();
		end
	end
endmodule
`default_nettype wire
